// file: split_timer_defines.svh
`ifndef SPLIT_TIMER_DEFINES_SVH
`define SPLIT_TIMER_DEFINES_SVH
// Register offsets
`define OFS_CTRL 3'h0
`define OFS_MODE 3'h1
`define OFS_MODE1 3'h2
`define OFS_LOW_CNT 3'h3
`define OFS_HIGH_CNT 3'h4
`define OFS_LOW_RLD 3'h5
`define OFS_HIGH_RLD 3'h6
// Control register fields
`define CTRL_MAIN_OVF 7
`define CTRL_EXT_FLAG 6
`define CTRL_LOW_OVF 5
`define CTRL_LOW_IE 4
`define CTRL_NEG_EN 3
`define CTRL_RUN 2
`define CTRL_CNT_SEL 1
`define CTRL_CAP_RLD 0
// Mode register fields
`define MODE_SPLIT 7
`define MODE_LOW_X12 6
`define MODE_POS_EN 5
`define MODE_X12 4
`define MODE_LOW_RUN 3
`define MODE_LOW_RUN_CLR 2
`define MODE_CLK_OE 1
`define MODE_MSEL_LO 0
// Mode register 1 fields
`define MODE1_LOW_CS 7
`define MODE1_OVF_IGN 6
`define MODE1_TRIG_INV 5
`define MODE1_CKS 4
`define MODE1_MSEL_HI 3
`define MODE1_CAP_SEL_MSB 2
`define MODE1_CAP_SEL_LSB 0
// Reset values and timing
`define RST_BYTE 8'h00
`define BYTE_MAX 8'hFF
`define PRESCALE_LAST 4'hB
`endif

// file: split_timer_pkg.sv
`default_nettype none
package split_timer_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } bus_req_t;

  typedef struct packed {
    logic sbrg_ovf;
    logic t0_ovf;
    logic cmp_evt;
    logic t1_ovf;
    logic int1_evt;
  } tick_in_t;

  typedef enum logic [2:0] {
    MODE_AR_EXT = 3'h0,
    MODE_AR_RLD = 3'h1,
    MODE_CAP = 3'h2,
    MODE_CAP_ZERO = 3'h3,
    MODE_PWM8 = 3'h4,
    MODE_RSV5 = 3'h5,
    MODE_DUTY = 3'h6,
    MODE_RSV7 = 3'h7
  } mode_t;

  typedef enum logic [2:0] {
    DUTY_IDLE = 3'b001,
    DUTY_HIGH = 3'b010,
    DUTY_LOW = 3'b100
  } duty_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] mode1;
    logic [7:0] low_cnt;
    logic [7:0] high_cnt;
    logic [7:0] low_rld;
    logic [7:0] high_rld;
    logic [3:0] prescale;
    logic trig_prev;
    logic pin_prev;
    duty_t duty;
    logic clk_out;
    logic [7:0] rdata;
  } state_t;
endpackage : split_timer_pkg
`default_nettype wire

// file: split_timer_pwm_clockout.sv
// Functional notes
// - Split capture auto-zero runs two 8-bit counters, split interrupt scheme.
// - Split auto-zero trigger copies high count to high capture, clears high count.
// - Split PWM: high count with high reload forms the period counter.
// - PWM: low count is compare value, low reload buffers new duty.
// - PWM: high overflow sets main flag and loads low reload into low count.
// - PWM waveform reaches the clock-out pin only with clock output enabled.
// - Split duty capture runs two 8-bit counters, split interrupt scheme.
// - Duty: second edge captures high count; count left at stop is period.
// - Duty: second edge sets external flag only with negative-edge enable.
// - Duty: third edge clears run bit; sets external flag with positive-edge enable.
// - Split: low-byte overflow replaces timer overflow event for pin and peripherals.
// - Reload select with clock output enabled gives 50 percent clock out.
// - 16-bit clock-out: counter counts, reloads from reload pair on overflow.
// - Clock-out frequency is timer clock over 2 x (65536 - reload).
// - 16-bit rollover sets main flag; ignore bit blocks its interrupt.
// - Split clock-out toggles on low overflow; low count reloads each overflow.
// - Low overflow sets low flag; interrupt only with low interrupt enable.
// - Low count serves baud source and clock-out at one overflow rate.
// - Split flags stay set until software clears them.
// - Mode code 100 selects 8-bit PWM, valid only in split operation.
//
// Strobed register access and the register addresses were chosen for this implementation.
`include "split_timer_defines.svh"
`default_nettype none
module split_timer_pwm_clockout (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire split_timer_pkg::bus_req_t bus,
  output logic [7:0] reg_rdata,
  // Event and pin inputs
  input wire logic count_pin,
  input wire logic [7:0] trigger_sources,
  input wire split_timer_pkg::tick_in_t ticks,
  // Outputs
  output logic clock_out_pin,
  output logic timer_overflow_event,
  output logic low_byte_overflow_event,
  output logic irq_request
);

  function automatic logic [8:0] inc8(input logic [7:0] v);
    inc8 = {1'b0, v} + 9'h001;
  endfunction : inc8

  function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic hi_clk(input logic [2:0] code, input logic pre,
                                  input logic pin, input logic split,
                                  input logic low_ovf, input split_timer_pkg::tick_in_t t);
    case (code)
      3'h0: hi_clk = pre;
      3'h1: hi_clk = pin;
      3'h2: hi_clk = 1'b1;
      3'h3: hi_clk = split ? low_ovf : t.int1_evt;
      3'h4: hi_clk = t.sbrg_ovf;
      3'h5: hi_clk = t.t0_ovf;
      3'h6: hi_clk = t.cmp_evt;
      default: hi_clk = t.t1_ovf;
    endcase
  endfunction : hi_clk

  function automatic logic lo_clk(input logic [1:0] code, input logic pre,
                                  input split_timer_pkg::tick_in_t t);
    case (code)
      2'h0: lo_clk = pre;
      2'h1: lo_clk = 1'b1;
      2'h2: lo_clk = t.sbrg_ovf;
      default: lo_clk = t.int1_evt;
    endcase
  endfunction : lo_clk

  split_timer_pkg::state_t s_q;
  split_timer_pkg::state_t s_d;
  split_timer_pkg::mode_t mode_code;
  logic split;
  logic run_h;
  logic oe;
  logic cap_rld;
  logic pre_tick;
  logic pin_fall;
  logic trig_lvl;
  logic rise;
  logic fall;
  logic ext_hit;
  logic duty_mode;
  logic pwm_mode;
  logic first_edge;
  logic second_edge;
  logic third_edge;
  logic exf_set;
  logic capture;
  logic zero;
  logic reload_ext;
  logic hi_en;
  logic hi_src;
  logic lo_step;
  logic lo_tick;
  logic hi_step;
  logic ovf_l;
  logic ovf_h;
  logic [8:0] low_inc;
  logic [8:0] high_inc;
  logic wr_ctrl;
  logic wr_low;
  logic wr_high;
  logic [7:0] rd_mux;

  assign split = s_q.mode[`MODE_SPLIT];
  assign run_h = s_q.ctrl[`CTRL_RUN];
  assign oe = s_q.mode[`MODE_CLK_OE];
  assign cap_rld = s_q.ctrl[`CTRL_CAP_RLD];
  assign mode_code = split_timer_pkg::mode_t'({s_q.mode1[`MODE1_MSEL_HI], cap_rld,
                                               s_q.mode[`MODE_MSEL_LO]});
  assign pre_tick = (s_q.prescale == `PRESCALE_LAST);
  assign pin_fall = s_q.pin_prev & ~count_pin;
  assign trig_lvl = trigger_sources[s_q.mode1[`MODE1_CAP_SEL_MSB:`MODE1_CAP_SEL_LSB]]
                    ^ s_q.mode1[`MODE1_TRIG_INV];
  assign rise = ~s_q.trig_prev & trig_lvl;
  assign fall = s_q.trig_prev & ~trig_lvl;
  assign ext_hit = (fall & s_q.ctrl[`CTRL_NEG_EN]) | (rise & s_q.mode[`MODE_POS_EN]);
  assign duty_mode = (mode_code == split_timer_pkg::MODE_DUTY);
  assign pwm_mode = split & (mode_code == split_timer_pkg::MODE_PWM8);
  // Duty capture sequence: first rising edge clears the count and starts counting, never flags
  assign first_edge = duty_mode & run_h & (s_q.duty == split_timer_pkg::DUTY_IDLE) & rise;
  assign second_edge = duty_mode & (s_q.duty == split_timer_pkg::DUTY_HIGH) & fall;
  assign third_edge = duty_mode & (s_q.duty == split_timer_pkg::DUTY_LOW) & rise;
  assign exf_set = duty_mode ? ((second_edge & s_q.ctrl[`CTRL_NEG_EN]) |
                                (third_edge & s_q.mode[`MODE_POS_EN])) : ext_hit;
  assign capture = ((mode_code == split_timer_pkg::MODE_CAP) |
                    (mode_code == split_timer_pkg::MODE_CAP_ZERO)) & ext_hit | second_edge;
  assign zero = ((mode_code == split_timer_pkg::MODE_CAP_ZERO) & ext_hit) | first_edge;
  assign reload_ext = (mode_code == split_timer_pkg::MODE_AR_RLD) & ext_hit;

  // Counter clocking; in 16-bit form the high byte advances on the low carry
  assign hi_en = run_h & (~duty_mode | (s_q.duty != split_timer_pkg::DUTY_IDLE));
  // Split low byte steps on its own source, so the high byte takes its carry with no loop
  assign lo_tick = s_q.mode[`MODE_LOW_RUN] & ~pwm_mode &
                   lo_clk({s_q.mode1[`MODE1_LOW_CS], s_q.mode[`MODE_LOW_X12]},
                          pre_tick, ticks);
  assign lo_step = split ? lo_tick : (hi_en & hi_src);
  assign low_inc = inc8(s_q.low_cnt);
  assign high_inc = inc8(s_q.high_cnt);
  assign ovf_l = lo_step & low_inc[8];
  assign hi_src = hi_clk({s_q.mode1[`MODE1_CKS], s_q.mode[`MODE_X12], s_q.ctrl[`CTRL_CNT_SEL]},
                         pre_tick, pin_fall, split, lo_tick & low_inc[8], ticks);
  assign hi_step = split ? (hi_en & hi_src) : ovf_l;
  assign ovf_h = hi_step & high_inc[8];

  // Split: low overflow feeds the pin and other peripherals at one shared rate; 16-bit: high overflow does
  assign timer_overflow_event = split ? ovf_l : ovf_h;
  assign low_byte_overflow_event = split & ovf_l;
  assign irq_request = (s_q.ctrl[`CTRL_MAIN_OVF] & ~s_q.mode1[`MODE1_OVF_IGN]) |
                       s_q.ctrl[`CTRL_EXT_FLAG] |
                       (s_q.ctrl[`CTRL_LOW_OVF] & s_q.ctrl[`CTRL_LOW_IE]);
  assign clock_out_pin = s_q.clk_out;
  assign reg_rdata = s_q.rdata;

  assign wr_ctrl = bus.we & hit(bus.addr, `OFS_CTRL);
  assign wr_low = bus.we & hit(bus.addr, `OFS_LOW_CNT);
  assign wr_high = bus.we & hit(bus.addr, `OFS_HIGH_CNT);

  always_comb begin
    case (bus.addr)
      `OFS_CTRL: rd_mux = s_q.ctrl;
      `OFS_MODE: rd_mux = s_q.mode;
      `OFS_MODE1: rd_mux = s_q.mode1;
      `OFS_LOW_CNT: rd_mux = s_q.low_cnt;
      `OFS_HIGH_CNT: rd_mux = s_q.high_cnt;
      `OFS_LOW_RLD: rd_mux = s_q.low_rld;
      `OFS_HIGH_RLD: rd_mux = s_q.high_rld;
      default: rd_mux = `RST_BYTE;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.prescale = pre_tick ? 4'h0 : s_q.prescale + 4'h1;
    s_d.pin_prev = count_pin;
    s_d.trig_prev = trig_lvl;
    s_d.rdata = bus.re ? rd_mux : `RST_BYTE;

    // Low byte
    if (lo_step) begin
      s_d.low_cnt = low_inc[7:0];
    end
    if (split & ovf_l) begin
      s_d.low_cnt = s_q.low_rld;
    end
    // High byte, and the low byte too when running as one 16-bit counter or in split PWM
    if (hi_step) begin
      s_d.high_cnt = high_inc[7:0];
    end
    if ((ovf_h & ~cap_rld) | reload_ext) begin
      s_d.high_cnt = s_q.high_rld;
      if (!split) begin
        s_d.low_cnt = s_q.low_rld;
      end
    end
    if (pwm_mode & ovf_h) begin
      s_d.low_cnt = s_q.low_rld;
    end
    if (capture) begin
      s_d.high_rld = s_q.high_cnt;
      if (!split) begin
        s_d.low_rld = s_q.low_cnt;
      end
    end
    if (zero) begin
      s_d.high_cnt = `RST_BYTE;
      if (!split) begin
        s_d.low_cnt = `RST_BYTE;
      end
    end

    // Duty capture sequencer
    case (s_q.duty)
      split_timer_pkg::DUTY_IDLE: begin
        if (first_edge) begin
          s_d.duty = split_timer_pkg::DUTY_HIGH;
        end
      end
      split_timer_pkg::DUTY_HIGH: begin
        if (!run_h || !duty_mode) begin
          s_d.duty = split_timer_pkg::DUTY_IDLE;
        end else if (second_edge) begin
          s_d.duty = split_timer_pkg::DUTY_LOW;
        end
      end
      split_timer_pkg::DUTY_LOW: begin
        if (!run_h || !duty_mode || third_edge) begin
          s_d.duty = split_timer_pkg::DUTY_IDLE;
        end
      end
      default: s_d.duty = split_timer_pkg::DUTY_IDLE;
    endcase

    // Clock-out pin: toggle halves the overflow rate, so duty is exactly 50 percent
    if (!oe) begin
      s_d.clk_out = 1'b0;
    end else if (pwm_mode) begin
      s_d.clk_out = (s_q.high_cnt < s_q.low_cnt);
    end else if ((split | ~cap_rld) & timer_overflow_event) begin
      s_d.clk_out = ~s_q.clk_out;
    end

    // Software writes win over counting; flags keep set-over-clear
    if (bus.we) begin
      case (bus.addr)
        `OFS_CTRL: s_d.ctrl = bus.wdata;
        `OFS_MODE: s_d.mode = bus.wdata;
        `OFS_MODE1: s_d.mode1 = bus.wdata;
        `OFS_LOW_CNT: s_d.low_cnt = bus.wdata;
        `OFS_HIGH_CNT: s_d.high_cnt = bus.wdata;
        `OFS_LOW_RLD: s_d.low_rld = bus.wdata;
        `OFS_HIGH_RLD: s_d.high_rld = bus.wdata;
        default: s_d.rdata = s_d.rdata;
      endcase
    end
    if (ovf_h) begin
      s_d.ctrl[`CTRL_MAIN_OVF] = 1'b1;
    end
    if (split & ovf_l) begin
      s_d.ctrl[`CTRL_LOW_OVF] = 1'b1;
    end
    if (exf_set) begin
      s_d.ctrl[`CTRL_EXT_FLAG] = 1'b1;
    end
    if (third_edge) begin
      s_d.ctrl[`CTRL_RUN] = 1'b0;
    end
    // Low run auto-clear on high overflow (reload modes) or capture
    if (split & s_q.mode[`MODE_LOW_RUN_CLR] &
        ((ovf_h & ~cap_rld & ~s_q.mode1[`MODE1_MSEL_HI]) | capture)) begin
      s_d.mode[`MODE_LOW_RUN] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{ctrl: `RST_BYTE, mode: `RST_BYTE, mode1: `RST_BYTE, low_cnt: `RST_BYTE,
               high_cnt: `RST_BYTE, low_rld: `RST_BYTE, high_rld: `RST_BYTE,
               prescale: 4'h0, trig_prev: 1'b0, pin_prev: 1'b0,
               duty: split_timer_pkg::DUTY_IDLE, clk_out: 1'b0, rdata: `RST_BYTE};
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  AST_SPLIT_AUTO_ZERO: assert property (
    split && mode_code == split_timer_pkg::MODE_CAP_ZERO && ext_hit && !bus.we
    |=> s_q.high_cnt == 8'h00 && s_q.high_rld == $past(s_q.high_cnt))
    else $error("split auto-zero capture wrong");

  AST_PWM_DUTY_LOAD: assert property (
    pwm_mode && ovf_h && !bus.we
    |=> s_q.low_cnt == $past(s_q.low_rld) && s_q.ctrl[`CTRL_MAIN_OVF])
    else $error("pwm overflow did not load duty or set flag");

  AST_PIN_GATED: assert property (
    !oe |=> !clock_out_pin)
    else $error("clock-out pin driven while output disabled");

  AST_DUTY_CAPTURE: assert property (
    split && second_edge && !bus.we |=> s_q.high_rld == $past(s_q.high_cnt))
    else $error("duty second edge did not capture high count");

  AST_DUTY_SECOND_FLAG: assert property (
    second_edge && !s_q.ctrl[`CTRL_NEG_EN] && !s_q.ctrl[`CTRL_EXT_FLAG] && !bus.we
    |=> !s_q.ctrl[`CTRL_EXT_FLAG])
    else $error("second edge set external flag without enable");

  AST_DUTY_STOP: assert property (
    third_edge && s_q.mode[`MODE_POS_EN] && !bus.we
    |=> !s_q.ctrl[`CTRL_RUN] && s_q.ctrl[`CTRL_EXT_FLAG] ##1 !hi_step)
    else $error("third edge did not stop counter");

  AST_SPLIT_EVENT: assert property (
    split |-> timer_overflow_event == low_byte_overflow_event &&
    (!timer_overflow_event || (s_q.low_cnt == `BYTE_MAX && s_q.mode[`MODE_LOW_RUN])))
    else $error("split overflow event not from low byte");

  AST_CLOCK_TOGGLE: assert property (
    oe && !split && !cap_rld && ovf_h && !bus.we
    |=> clock_out_pin != $past(clock_out_pin))
    else $error("clock-out pin missed a toggle");

  AST_RELOAD_16: assert property (
    !split && !cap_rld && ovf_h && !bus.we
    |=> {s_q.high_cnt, s_q.low_cnt} == $past({s_q.high_rld, s_q.low_rld}))
    else $error("16-bit reload wrong");

  AST_FLAG_STICKY: assert property (
    s_q.ctrl[`CTRL_MAIN_OVF] && !wr_ctrl |=> s_q.ctrl[`CTRL_MAIN_OVF])
    else $error("main overflow flag cleared by hardware");

  AST_LOW_FLAG: assert property (
    split && ovf_l |=> s_q.ctrl[`CTRL_LOW_OVF])
    else $error("low overflow did not set low flag");

  AST_IGNORE_IRQ: assert property (
    s_q.mode1[`MODE1_OVF_IGN] && !s_q.ctrl[`CTRL_EXT_FLAG] &&
    !(s_q.ctrl[`CTRL_LOW_OVF] && s_q.ctrl[`CTRL_LOW_IE]) |-> !irq_request)
    else $error("ignored overflow raised interrupt");

  AST_LOW_RELOAD: assert property (
    split && ovf_l && !bus.we |=> s_q.low_cnt == $past(s_q.low_rld))
    else $error("split low byte did not reload");

  AST_SPLIT_TOGGLE: assert property (
    oe && split && !pwm_mode && low_byte_overflow_event
    |=> clock_out_pin != $past(clock_out_pin))
    else $error("split clock-out pin missed a toggle");

  AST_DUTY_SECOND_SET: assert property (
    second_edge && s_q.ctrl[`CTRL_NEG_EN] |=> s_q.ctrl[`CTRL_EXT_FLAG])
    else $error("second edge did not set external flag");

  AST_MAIN_IRQ: assert property (
    s_q.ctrl[`CTRL_MAIN_OVF] && !s_q.mode1[`MODE1_OVF_IGN] |-> irq_request)
    else $error("main overflow flag raised no interrupt");

  AST_HIGH_WRITE: assert property (
    wr_high |=> s_q.high_cnt == $past(bus.wdata))
    else $error("high count write lost");

  AST_LOW_WRITE: assert property (
    wr_low |=> s_q.low_cnt == $past(bus.wdata))
    else $error("low count write lost");

endmodule : split_timer_pwm_clockout
`default_nettype wire

// file: split_timer_pwm_clockout_tb_top.sv
`include "split_timer_defines.svh"
`default_nettype none
module split_timer_pwm_clockout_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, count_pin, clock_out_pin, irq_request, go, trig;
  logic timer_overflow_event, low_byte_overflow_event, split_watch;
  split_timer_pkg::bus_req_t bus;
  split_timer_pkg::tick_in_t ticks;
  logic [7:0] reg_rdata, trigger_sources, high_len, low_len, d, v, p, dd, hl, ll;
  logic [1:0] phase;
  logic [15:0] last_half, half, hi;
  logic [31:0] rng_q = 32'hACA212EC;
  int miscompares, num_checks, cycles, ovf_seen;

  split_timer_pwm_clockout uut (.clk(clk), .arst_n(arst_n), .bus(bus), .reg_rdata(reg_rdata),
    .count_pin(count_pin), .trigger_sources(trigger_sources), .ticks(ticks),
    .clock_out_pin(clock_out_pin), .timer_overflow_event(timer_overflow_event),
    .low_byte_overflow_event(low_byte_overflow_event), .irq_request(irq_request));
  split_timer_wave_src src (.clk(clk), .go(go), .high_len(high_len), .low_len(low_len),
    .trig(trig), .phase(phase), .clock_out_pin(clock_out_pin), .last_half(last_half));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // Edge timing of trigger paths is only fixed to within a cycle, hence the window
  task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi_b);
    num_checks++;
    if ((got >= lo && got <= hi_b) !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h..%0h", $time, got, lo, hi_b);
    end
  endtask : chk_rng

  task automatic wr(input logic [2:0] a, input logic [7:0] wd);
    @(posedge clk);
    bus <= '{a, wd, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] rdv);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 rdv = reg_rdata;
  endtask : rd

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk);
    // Step off the edge so outputs launched there have settled
    #1;
  endtask : wait_cycles

  task automatic wait_phase(input logic [1:0] ph);
    int n;
    n = 0;
    while (phase !== ph && n < 1000) begin
      @(posedge clk);
      n++;
    end
    chk(phase, ph);
  endtask : wait_phase

  task automatic do_reset;
    @(posedge clk);
    arst_n <= 1'b0;
    go <= 1'b0;
    wait_cycles(12);
    arst_n <= 1'b1;
  endtask : do_reset

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Background noise on the unused clock and trigger sources
  always @(posedge clk) begin
    rng_q <= xorshift(rng_q);
    count_pin <= rng_q[0];
    ticks <= split_timer_pkg::tick_in_t'(rng_q[5:1] & {5{rng_q[6]}});
    trigger_sources <= {rng_q[13:7], trig};
  end

  always @(negedge clk) begin
    cycles++;
    if (split_watch) begin
      chk(timer_overflow_event, low_byte_overflow_event);
      if (low_byte_overflow_event === 1'b1) begin
        ovf_seen++;
      end
    end
    if (cycles == 40000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    arst_n = 1'b0;
    bus = '0;
    go = 1'b0;
    high_len = 8'h01;
    low_len = 8'h01;
    split_watch = 1'b0;
    wait_cycles(12);
    arst_n <= 1'b1;
    // Reset values, index 7 unmapped, read data stands one cycle
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], d);
      chk(d, 8'h00);
    end
    wr(3'h7, 8'h5A);
    rd(3'h7, d);
    chk(d, 8'h00);
    v = rng_q[7:0];
    wr(`OFS_LOW_RLD, v);
    rd(`OFS_LOW_RLD, d);
    chk(d, v);
    @(posedge clk);
    #1 chk(reg_rdata, 8'h00);
    // 16-bit clock-out, timer clock every cycle
    do_reset();
    v = 8'hC0 | rng_q[4:0];
    half = 16'h0100 - v;
    wr(`OFS_MODE, 8'h10);
    wr(`OFS_HIGH_RLD, 8'hFF);
    wr(`OFS_LOW_RLD, v);
    wr(`OFS_HIGH_CNT, 8'hFF);
    wr(`OFS_LOW_CNT, v);
    wr(`OFS_MODE, 8'h12);
    wr(`OFS_CTRL, 8'h04);
    wait_cycles(6 * half + 10);
    chk(last_half, half);
    wait_cycles(half);
    chk(last_half, half);
    rd(`OFS_CTRL, d);
    chk(d[7], 1'b1);
    chk(irq_request, 1'b1);
    wr(`OFS_MODE1, 8'h40);
    wait_cycles(2);
    chk(irq_request, 1'b0);
    // Split clock-out from the low byte
    do_reset();
    v = 8'hC0 | rng_q[12:8];
    half = 16'h0100 - v;
    wr(`OFS_MODE, 8'hC0);
    wr(`OFS_LOW_RLD, v);
    wr(`OFS_LOW_CNT, v);
    wr(`OFS_MODE, 8'hC2);
    wr(`OFS_MODE, 8'hCA);
    ovf_seen = 0;
    split_watch = 1'b1;
    wait_cycles(4 * half + 10);
    chk(last_half, half);
    chk(ovf_seen[15:0], 16'h0004);
    rd(`OFS_CTRL, d);
    chk(d[5], 1'b1);
    chk(irq_request, 1'b0);
    wr(`OFS_CTRL, 8'h30);
    wait_cycles(2);
    chk(irq_request, 1'b1);
    split_watch = 1'b0;
    // Split 8-bit PWM
    do_reset();
    p = 8'hC0 | rng_q[3:0];
    dd = p + 8'h01 + {3'b000, rng_q[8:4]};
    wr(`OFS_MODE1, 8'h08);
    wr(`OFS_HIGH_RLD, p);
    wr(`OFS_HIGH_CNT, p);
    wr(`OFS_LOW_RLD, dd);
    wr(`OFS_MODE, 8'h92);
    wr(`OFS_CTRL, 8'h04);
    wait_cycles(3 * (256 - p));
    rd(`OFS_LOW_CNT, d);
    chk(d, dd);
    rd(`OFS_CTRL, d);
    chk(d[7], 1'b1);
    for (int g = 1; g >= 0; g--) begin
      hi = 16'h0000;
      repeat (256 - p) begin
        @(posedge clk);
        #1 hi = hi + {15'h0000, clock_out_pin};
      end
      chk(hi, g ? {8'h00, dd - p} : 16'h0000);
      wr(`OFS_MODE, 8'h90);
      wait_cycles(3);
    end
    // Split duty capture over every combination of the two edge enables
    for (int k = 0; k < 4; k++) begin
      do_reset();
      hl = 8'd10 + rng_q[3:0];
      ll = 8'd20 + rng_q[7:4];
      high_len <= hl;
      low_len <= ll;
      wr(`OFS_MODE1, 8'h08);
      wr(`OFS_MODE, k[1] ? 8'hB0 : 8'h90);
      wr(`OFS_CTRL, k[0] ? 8'h0D : 8'h05);
      go <= 1'b1;
      wait_phase(2'h2);
      wait_cycles(4);
      rd(`OFS_CTRL, d);
      chk(d[6], k[0]);
      wait_phase(2'h3);
      wait_cycles(4);
      rd(`OFS_CTRL, d);
      chk(d[6], k[0] | k[1]);
      chk(d[2], 1'b0);
      rd(`OFS_HIGH_RLD, d);
      chk_rng(d, hl - 8'd1, hl + 8'd1);
      rd(`OFS_HIGH_CNT, d);
      chk_rng(d, hl + ll - 8'd1, hl + ll + 8'd1);
    end
    // Split capture with auto-zero on a falling trigger edge
    do_reset();
    wr(`OFS_MODE, 8'h91);
    wr(`OFS_CTRL, 8'h0D);
    wait_cycles(40);
    go <= 1'b1;
    wait_phase(2'h2);
    wait_cycles(20);
    rd(`OFS_HIGH_CNT, d);
    chk_rng(d, 8'd16, 8'd26);
    rd(`OFS_HIGH_RLD, d);
    chk_rng(d, 8'd40, 8'd120);
    wait_cycles(300);
    rd(`OFS_CTRL, d);
    chk(d[7:6], 2'b11);
    wr(`OFS_CTRL, 8'h0D);
    rd(`OFS_CTRL, d);
    chk(d[6], 1'b0);
    complete_run();
  end
endmodule : split_timer_pwm_clockout_tb_top
`default_nettype wire

// file: split_timer_wave_src.sv
`default_nettype none
module split_timer_wave_src (
  // Clock
  input wire logic clk,
  // Waveform control
  input wire logic go,
  input wire logic [7:0] high_len,
  input wire logic [7:0] low_len,
  output logic trig,
  output logic [1:0] phase,
  // Clock-out pin load
  input wire logic clock_out_pin,
  output logic [15:0] last_half
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_q;
  logic [15:0] since_q;
  logic pin_prev_q;

  // Low lead-in, rising edge, high time, falling edge, low time, final rising edge
  always @(posedge clk) begin
    if (!go) begin
      trig <= 1'b0;
      phase <= 2'h0;
      left_q <= 8'h04;
    end else if (phase != 2'h3) begin
      if (left_q != 8'h00) begin
        left_q <= left_q - 8'h01;
      end else if (phase == 2'h0) begin
        trig <= 1'b1;
        phase <= 2'h1;
        left_q <= high_len - 8'h01;
      end else if (phase == 2'h1) begin
        trig <= 1'b0;
        phase <= 2'h2;
        left_q <= low_len - 8'h01;
      end else begin
        trig <= 1'b1;
        phase <= 2'h3;
      end
    end
  end

  // Measures the cycles between two toggles of the pin; a stuck pin keeps the old figure
  always @(posedge clk) begin
    pin_prev_q <= clock_out_pin;
    if (clock_out_pin !== pin_prev_q) begin
      last_half <= since_q;
      since_q <= 16'h0001;
    end else begin
      since_q <= since_q + 16'h0001;
    end
  end
endmodule : split_timer_wave_src
`default_nettype wire
